/* hw/opp_pkg.sv */
// constants shared by both ends of the nibble programming link
//==========================================================
// Contract
// (R1) Raise programming supply, then lower select
// (R2) Nibbles move on programming clock falling edge
// (R3) Address: four nibbles, bits 0-9 first
// (R4) Fourth address nibble: bit2 test, bit3 option
// (R5) Ignore unused bits of nibbles three, four
// (R6) Flags pick test, option or program space
// (R7) Code word: four nibbles, lowest first
// (R8) Verify returns zeros in top two bits
// (R9) Direction pin picks program or verify
// (R10) Verify advances code address by one
// (R11) Select high ends cycle; resend address
// (R12) Lock set: code reads return all ones
// (R13) Lock clear: code reads return stored data
// (R14) Programmer defines every option bit
// (R15) Option bits: wake enables, oscillator type
// (R16) Option bit 9: watchdog clear style
// (R17) Option bits 10, 11 programmed zero
// (R18) Option bits 12, 13: watchdog source, disable
// (R19) 1024x14 program array plus option word
// (R20) Select high resets nibble phase counter
package opp_pkg;
    //==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int LINK_HALF_NS  = 320;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HV_SETTLE_NS  = 2000;
    localparam int HV_SETTLE_CYC = (HV_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEL_GAP_NS    = 640;
    localparam int SEL_GAP_CYC   = (SEL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W       = 8;
    //==========================================================
    // link layout
    localparam int CODE_AW = 10;
    localparam int WORD_W  = 14;
    localparam int NIB_W   = 4;
    localparam int PHASE_W = 3;
    localparam logic [PHASE_W-1:0] PH_ADDR0 = 3'h0;
    localparam logic [PHASE_W-1:0] PH_ADDR1 = 3'h1;
    localparam logic [PHASE_W-1:0] PH_ADDR2 = 3'h2;
    localparam logic [PHASE_W-1:0] PH_ADDR3 = 3'h3;
    localparam logic [PHASE_W-1:0] PH_DATA0 = 3'h4;
    localparam logic [PHASE_W-1:0] PH_DATA3 = 3'h7;
    localparam int TEST_SPACE_FLAG_BIT = 2;
    localparam int OPTION_SPACE_FLAG_BIT = 3;
    localparam logic [NIB_W-1:0] NIBBLE_IDLE = 4'h0;
    localparam logic [1:0] TOP_PAD = 2'h0;
    typedef enum logic [1:0] {SPACE_CODE, SPACE_OPTION, SPACE_TEST, SPACE_NONE} opp_space_e;
    //==========================================================
    // option word and protection
    localparam int OPT_WAKE_W      = 8;
    localparam int OPT_OSC_BIT     = 8;
    localparam int OPT_WDT_CLR_BIT = 9;
    localparam int OPT_WDT_SRC_BIT = 12;
    localparam int OPT_WDT_DIS_BIT = 13;
    localparam int LOCK_DATA_BIT   = 0;
    localparam logic [WORD_W-1:0] WORD_RESET   = 14'h0000;
    localparam logic [WORD_W-1:0] PROTECT_WORD = 14'h3fff;
    //==========================================================
    // programmer registers
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [REG_AW-1:0] REG_ADDR   = 8'h04;
    localparam logic [REG_AW-1:0] REG_WDATA  = 8'h08;
    localparam logic [REG_AW-1:0] REG_RDATA  = 8'h0c;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h10;
    localparam int CTRL_GO_BIT    = 0;
    localparam int CTRL_DIR_BIT   = 1;
    localparam int CTRL_TEST_SPACE_FLAG_BIT  = 2;
    localparam int CTRL_OPTION_SPACE_FLAG_BIT  = 3;
    localparam int CTRL_NEWA_BIT  = 4;
    localparam int CTRL_CLOSE_BIT = 5;
endpackage : opp_pkg

/* hw/opp_link_if.sv */
// link wires between programmer and device
`timescale 1ns/1ps
interface opp_link_if;
    import opp_pkg::*;
    logic [NIB_W-1:0] host_nibble;
    logic             host_nibble_oe;
    logic [NIB_W-1:0] dev_nibble;
    logic             dev_nibble_oe;
    logic             prog_clock_pin;
    logic             prog_select_pin_n;
    logic             prog_direction_pin;
    logic             reset_hv_pin;
    logic [NIB_W-1:0] nibble_bus;

    // resolved shared bus level
    assign nibble_bus = dev_nibble_oe ? dev_nibble
                      : (host_nibble_oe ? host_nibble : NIBBLE_IDLE);

    modport device (
        input  nibble_bus, prog_clock_pin, prog_select_pin_n,
        input  prog_direction_pin, reset_hv_pin,
        output dev_nibble, dev_nibble_oe
    );
    modport programmer (
        input  nibble_bus,
        output host_nibble, host_nibble_oe, prog_clock_pin,
        output prog_select_pin_n, prog_direction_pin, reset_hv_pin
    );
endinterface : opp_link_if

/* hw/opp_sync_edge.sv */
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module opp_sync_edge #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out,
    output logic      [W-1:0] fall_out,
    output logic      [W-1:0] rise_out
);
    logic [W-1:0] meta;
    logic [W-1:0] prev;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta  <= '0;
            q_out <= '0;
            prev  <= '0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
            prev  <= q_out;
        end
    end

    assign fall_out = prev & ~q_out;
    assign rise_out = ~prev & q_out;
endmodule : opp_sync_edge

/* hw/opp_device.sv */
// device end: program array, option word and nibble port
`timescale 1ns/1ps
module opp_device
    import opp_pkg::*;
#(
    // arbitrary content of the read-only test space
    parameter logic [WORD_W-1:0] TEST_WORD = 14'h0000
) (
    input  wire logic                  clk_in,
    input  wire logic                  reset_n_in,
    opp_link_if.device                 link,
    input  wire logic [CODE_AW-1:0]    fetch_addr_in,
    output logic      [WORD_W-1:0]     fetch_data_out,
    output logic      [OPT_WAKE_W-1:0] wake_enable_bits_out,
    output logic                       osc_type_bit_out,
    output logic                       wdt_clear_style_bit_out,
    output logic                       wdt_clock_source_bit_out,
    output logic                       wdt_disable_bit_out,
    output logic                       code_locked_out
);
    //==========================================================
    // pin synchronisers
    logic [7:0]       s_q;
    logic [7:0]       s_fall;
    logic [NIB_W-1:0] bus_s;
    logic             clk_fall;
    logic             sel_n_s;
    logic             dir_s;
    logic             hv_s;
    logic             session;

    opp_sync_edge #(.W(8)) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .d_in       ({link.reset_hv_pin, link.prog_direction_pin,
                      link.prog_select_pin_n, link.prog_clock_pin, link.nibble_bus}),
        .q_out      (s_q),
        .fall_out   (s_fall),
        .rise_out   ()
    );

    assign bus_s    = s_q[NIB_W-1:0];
    assign clk_fall = s_fall[4];
    assign sel_n_s  = s_q[5];
    assign dir_s    = s_q[6];
    assign hv_s     = s_q[7];
    // session needs supply raised and select low
    assign session  = hv_s & ~sel_n_s; // R1

    //==========================================================
    // storage
    logic [WORD_W-1:0]  code_mem [0:(1<<CODE_AW)-1]; // R19
    logic [WORD_W-1:0]  option_word;                 // R19
    logic               lock;
    logic [PHASE_W-1:0] phase;
    logic [CODE_AW-1:0] addr;
    logic               test_space_flag;
    logic               option_space_flag;
    logic [11:0]        wr_low;
    logic [WORD_W-1:0]  wr_word;
    logic [WORD_W-1:0]  rd_word;
    opp_space_e         space;
    logic               take;
    logic               last;

    assign take    = session & clk_fall; // R2
    assign last    = (phase == PH_DATA3);
    assign wr_word = {bus_s[1:0], wr_low}; // R7

    //==========================================================
    // space decode
    always_comb begin
        case ({test_space_flag, option_space_flag}) // R6
            2'b10:   space = SPACE_TEST;
            2'b01:   space = SPACE_OPTION;
            2'b00:   space = SPACE_CODE;
            default: space = SPACE_NONE;
        endcase
    end

    //==========================================================
    // nibble phase
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase <= PH_ADDR0;
        end else if (!session) begin
            phase <= PH_ADDR0; // R20 R11
        end else if (take) begin
            if (last) begin
                phase <= PH_DATA0;
            end else begin
                phase <= phase + 3'h1;
            end
        end
    end

    //==========================================================
    // address capture and auto-increment
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr <= '0;
            test_space_flag <= 1'b0;
            option_space_flag <= 1'b0;
        end else if (take) begin
            case (phase) // R3
                PH_ADDR0: addr[3:0] <= bus_s;
                PH_ADDR1: addr[7:4] <= bus_s;
                PH_ADDR2: addr[9:8] <= bus_s[1:0]; // R5
                PH_ADDR3: begin
                    test_space_flag <= bus_s[TEST_SPACE_FLAG_BIT]; // R4 R5
                    option_space_flag <= bus_s[OPTION_SPACE_FLAG_BIT]; // R4
                end
                PH_DATA3: begin
                    if (dir_s) begin
                        addr <= addr + 10'h001; // R10
                    end
                end
                default: ;
            endcase
        end
    end

    //==========================================================
    // write word assembly and commit
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_low <= '0;
        end else if (take && !dir_s) begin
            case (phase) // R7
                3'h4:    wr_low[3:0]  <= bus_s;
                3'h5:    wr_low[7:4]  <= bus_s;
                3'h6:    wr_low[11:8] <= bus_s;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (take && !dir_s && last && space == SPACE_CODE) begin
            code_mem[addr] <= wr_word; // R9
        end
        fetch_data_out <= code_mem[fetch_addr_in];
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            option_word <= WORD_RESET;
        end else if (take && !dir_s && last && space == SPACE_OPTION) begin
            option_word <= wr_word;
        end
    end

    // lock is one-time: once set it stays set
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lock <= 1'b0;
        end else if (take && !dir_s && last && space == SPACE_TEST) begin
            lock <= lock | wr_word[LOCK_DATA_BIT]; // R13
        end
    end

    //==========================================================
    // verify read path
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_word <= WORD_RESET;
        end else begin
            case (space)
                SPACE_CODE:   rd_word <= lock ? PROTECT_WORD : code_mem[addr]; // R12 R13
                SPACE_OPTION: rd_word <= option_word;
                SPACE_TEST:   rd_word <= TEST_WORD;
                default:      rd_word <= WORD_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link.dev_nibble    <= NIBBLE_IDLE;
            link.dev_nibble_oe <= 1'b0;
        end else begin
            link.dev_nibble_oe <= session & dir_s & phase[2]; // R9
            case (phase[1:0]) // R7
                2'h0:    link.dev_nibble <= rd_word[3:0];
                2'h1:    link.dev_nibble <= rd_word[7:4];
                2'h2:    link.dev_nibble <= rd_word[11:8];
                default: link.dev_nibble <= {TOP_PAD, rd_word[13:12]}; // R8
            endcase
        end
    end

    //==========================================================
    // configuration outputs
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_enable_bits_out     <= '0;
            osc_type_bit_out         <= 1'b0;
            wdt_clear_style_bit_out  <= 1'b0;
            wdt_clock_source_bit_out <= 1'b0;
            wdt_disable_bit_out      <= 1'b0;
            code_locked_out          <= 1'b0;
        end else begin
            wake_enable_bits_out     <= option_word[OPT_WAKE_W-1:0]; // R15
            osc_type_bit_out         <= option_word[OPT_OSC_BIT];    // R15
            wdt_clear_style_bit_out  <= option_word[OPT_WDT_CLR_BIT]; // R16
            wdt_clock_source_bit_out <= option_word[OPT_WDT_SRC_BIT]; // R18
            wdt_disable_bit_out      <= option_word[OPT_WDT_DIS_BIT]; // R18
            code_locked_out          <= lock;
        end
    end
endmodule : opp_device

/* hw/opp_programmer.sv */
// programmer end: register port drives nibble transfers on the link
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
module opp_programmer
    import opp_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    opp_link_if.programmer         link,
    input  wire logic [REG_AW-1:0] reg_addr_in,
    input  wire logic [REG_DW-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [REG_DW-1:0] reg_rdata_out
);
    typedef enum logic [2:0] {ST_IDLE, ST_HV_WAIT, ST_GAP, ST_HIGH, ST_LOW} opp_state_e;

    opp_state_e         state;
    logic [TIMER_W-1:0] timer;
    logic [PHASE_W-1:0] idx;
    logic               dir;
    logic               test_space_flag;
    logic               option_space_flag;
    logic [CODE_AW-1:0] addr;
    logic [WORD_W-1:0]  wdata;
    logic [WORD_W-1:0]  rdata;
    logic [NIB_W-1:0]   bus_s;
    logic               ctrl_wr;
    logic               go;
    logic               expired;
    logic [NIB_W-1:0]   nib;

    opp_sync_edge #(.W(NIB_W)) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .d_in       (link.nibble_bus),
        .q_out      (bus_s),
        .fall_out   (),
        .rise_out   ()
    );

    assign ctrl_wr = reg_wr_in && reg_addr_in == REG_CTRL;
    assign go      = ctrl_wr && reg_wdata_in[CTRL_GO_BIT] && state == ST_IDLE;
    assign expired = (timer == '0);

    //==========================================================
    // register writes
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr  <= '0;
            wdata <= WORD_RESET;
            dir   <= 1'b0;
            test_space_flag  <= 1'b0;
            option_space_flag  <= 1'b0;
        end else if (reg_wr_in && state == ST_IDLE) begin
            if (reg_addr_in == REG_ADDR) begin
                addr <= reg_wdata_in[CODE_AW-1:0];
            end
            if (reg_addr_in == REG_WDATA) begin
                wdata <= reg_wdata_in[WORD_W-1:0]; // R14 R17
            end
            if (ctrl_wr) begin
                dir  <= reg_wdata_in[CTRL_DIR_BIT]; // R9
                test_space_flag <= reg_wdata_in[CTRL_TEST_SPACE_FLAG_BIT];
                option_space_flag <= reg_wdata_in[CTRL_OPTION_SPACE_FLAG_BIT];
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                REG_ADDR:   reg_rdata_out <= REG_DW'(addr);
                REG_WDATA:  reg_rdata_out <= REG_DW'(wdata);
                REG_RDATA:  reg_rdata_out <= REG_DW'(rdata);
                REG_STATUS: reg_rdata_out <= REG_DW'({link.reset_hv_pin,
                                                      ~link.prog_select_pin_n,
                                                      state != ST_IDLE});
                default:    reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end

    //==========================================================
    // nibble to send at the current index
    always_comb begin
        case (idx) // R3 R4 R7
            3'h0:    nib = addr[3:0];
            3'h1:    nib = addr[7:4];
            3'h2:    nib = {2'h0, addr[9:8]};
            3'h3:    nib = {option_space_flag, test_space_flag, 2'h0};
            3'h4:    nib = wdata[3:0];
            3'h5:    nib = wdata[7:4];
            3'h6:    nib = wdata[11:8];
            default: nib = {TOP_PAD, wdata[13:12]};
        endcase
    end

    //==========================================================
    // link sequencer
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state                   <= ST_IDLE;
            timer                   <= '0;
            idx                     <= PH_ADDR0;
            link.prog_clock_pin     <= 1'b0;
            link.prog_select_pin_n  <= 1'b1;
            link.prog_direction_pin <= 1'b0;
            link.reset_hv_pin       <= 1'b0;
            link.host_nibble        <= NIBBLE_IDLE;
            link.host_nibble_oe     <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (ctrl_wr && reg_wdata_in[CTRL_CLOSE_BIT] && !go) begin
                        link.prog_select_pin_n <= 1'b1;
                        link.reset_hv_pin      <= 1'b0;
                    end else if (go) begin
                        if (!link.reset_hv_pin) begin
                            link.reset_hv_pin <= 1'b1; // R1
                            timer <= TIMER_W'(HV_SETTLE_CYC);
                            idx   <= PH_ADDR0;
                            state <= ST_HV_WAIT;
                        end else if (link.prog_select_pin_n) begin
                            idx   <= PH_ADDR0;
                            timer <= TIMER_W'(SEL_GAP_CYC);
                            state <= ST_GAP;
                        end else if (reg_wdata_in[CTRL_NEWA_BIT]) begin
                            link.prog_select_pin_n <= 1'b1; // R11
                            idx   <= PH_ADDR0;
                            timer <= TIMER_W'(SEL_GAP_CYC);
                            state <= ST_GAP;
                        end else begin
                            idx   <= PH_DATA0;
                            timer <= '0;
                            state <= ST_HIGH;
                        end
                    end
                end
                ST_HV_WAIT, ST_GAP: begin
                    if (expired) begin
                        link.prog_select_pin_n <= 1'b0; // R1
                        state <= ST_HIGH;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                ST_HIGH: begin
                    if (!link.prog_clock_pin) begin
                        link.prog_clock_pin <= 1'b1;
                        link.prog_direction_pin <= dir; // R9
                        link.host_nibble    <= nib;
                        link.host_nibble_oe <= !(dir && idx[2]);
                        timer <= TIMER_W'(LINK_HALF_CYC - 1);
                    end else if (expired) begin
                        link.prog_clock_pin <= 1'b0; // R2
                        timer <= TIMER_W'(LINK_HALF_CYC - 1);
                        state <= ST_LOW;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                ST_LOW: begin
                    link.host_nibble_oe <= !(dir && idx >= PH_ADDR3); // R2
                    if (expired) begin
                        if (idx == PH_DATA3) begin
                            state <= ST_IDLE;
                        end else begin
                            idx   <= idx + 3'h1;
                            state <= ST_HIGH;
                        end
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // capture verify nibbles as the clock falls
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata <= WORD_RESET;
        end else if (state == ST_HIGH && link.prog_clock_pin && expired && dir) begin
            case (idx) // R7
                3'h4:    rdata[3:0]   <= bus_s;
                3'h5:    rdata[7:4]   <= bus_s;
                3'h6:    rdata[11:8]  <= bus_s;
                3'h7:    rdata[13:12] <= bus_s[1:0];
                default: ;
            endcase
        end
    end
endmodule : opp_programmer

/* test/opp_link_assertions.sv */
// link protocol checks beside the shared interface
`timescale 1ns/1ps
module opp_link_assertions
    import opp_pkg::*;
(
    input wire logic             clk_in,
    input wire logic             reset_n_in,
    input wire logic [NIB_W-1:0] host_nibble,
    input wire logic             host_nibble_oe,
    input wire logic             dev_nibble_oe,
    input wire logic             prog_clock_pin,
    input wire logic             prog_select_pin_n,
    input wire logic             prog_direction_pin,
    input wire logic             reset_hv_pin
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    //==========================================================
    // link checks
    property p_hv_first; $fell(prog_select_pin_n) |-> reset_hv_pin; endproperty
    a_hv_first: assert property (p_hv_first) else $error("select without supply");
    property p_hv_hold; !reset_hv_pin |-> prog_select_pin_n; endproperty
    a_hv_hold: assert property (p_hv_hold) else $error("select low, supply off");
    property p_host_hold; $fell(prog_clock_pin) |-> $stable(host_nibble); endproperty
    a_host_hold: assert property (p_host_hold) else $error("nibble moved at fall");
    property p_no_clash; !(host_nibble_oe && dev_nibble_oe); endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive");
    property p_clk_high;
        $rose(prog_clock_pin) |-> prog_clock_pin [*8] ##1 !prog_clock_pin;
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("clock high time");
    property p_dev_dir; dev_nibble_oe |-> prog_direction_pin; endproperty
    a_dev_dir: assert property (p_dev_dir) else $error("device drives in program");
    property p_idle_clk; prog_select_pin_n |-> !prog_clock_pin; endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock runs unselected");
    property p_dev_rel; $rose(prog_select_pin_n) |-> ##[0:8] !dev_nibble_oe; endproperty
    a_dev_rel: assert property (p_dev_rel) else $error("device keeps bus");
    c_verify: cover property ($rose(dev_nibble_oe));
    c_open: cover property ($fell(prog_select_pin_n));
    c_jump: cover property ($rose(prog_select_pin_n) && reset_hv_pin);
endmodule : opp_link_assertions

/* test/testbench.sv */
// end-to-end bench: programmer registers drive the device over the link
`timescale 1ns/1ps
module testbench;
    import opp_pkg::*;
    localparam logic [WORD_W-1:0] TW = 14'h2a5c; // arbitrary test word
    localparam logic [5:0]        PG = 6'h11;
    localparam logic [5:0]        VF = 6'h13;
    logic                  clk_in = 1'b0;
    logic                  reset_n_in = 1'b0;
    logic [REG_AW-1:0]     ra = '0;
    logic [REG_DW-1:0]     rw = '0;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic [REG_DW-1:0]     rq;
    logic [REG_DW-1:0]     v;
    logic [CODE_AW-1:0]    fa = '0;
    logic [WORD_W-1:0]     fd;
    logic [OPT_WAKE_W-1:0] wk;
    logic                  osc, clr, src, dis, lck, pclk;
    logic [WORD_W-1:0]     ow [2] = '{14'h3155, 14'h02aa};
    int                    n_fail = 0;
    int                    cmp_count = 0;
    int                    nf = 0;
    int                    cyc = 0;
    opp_link_if link ();
    opp_programmer u_opp_programmer (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(link),
        .reg_addr_in(ra), .reg_wdata_in(rw), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rq));
    opp_device #(.TEST_WORD(TW)) u_opp_device (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .link(link), .fetch_addr_in(fa), .fetch_data_out(fd), .wake_enable_bits_out(wk),
        .osc_type_bit_out(osc), .wdt_clear_style_bit_out(clr), .wdt_clock_source_bit_out(src),
        .wdt_disable_bit_out(dis), .code_locked_out(lck));
    opp_link_assertions u_opp_link_assertions (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .host_nibble(link.host_nibble), .host_nibble_oe(link.host_nibble_oe),
        .dev_nibble_oe(link.dev_nibble_oe), .prog_clock_pin(link.prog_clock_pin),
        .prog_select_pin_n(link.prog_select_pin_n),
        .prog_direction_pin(link.prog_direction_pin), .reset_hv_pin(link.reset_hv_pin));
    //==========================================================
    // tasks
    task automatic chk(input string nm, input logic [REG_DW-1:0] e, input logic [REG_DW-1:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic reg_write(input logic [REG_AW-1:0] ad, input logic [REG_DW-1:0] d);
        @(posedge clk_in);
        ra <= ad;
        rw <= d;
        reg_wr <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [REG_AW-1:0] ad, output logic [REG_DW-1:0] d);
        @(posedge clk_in);
        ra <= ad;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1 d = rq;
    endtask : reg_read
    task automatic op(input logic [9:0] ad, input logic [13:0] d, input logic [5:0] c);
        reg_write(REG_ADDR, {22'h0, ad});
        reg_write(REG_WDATA, {18'h0, d});
        reg_write(REG_CTRL, {26'h0, c});
        v = 1;
        for (int k = 0; k < 600 && v[0] !== 1'b0; k++) reg_read(REG_STATUS, v);
        chk("idle", 0, v[0]);
    endtask : op
    task automatic vfy(input logic [9:0] ad, input logic [5:0] c, input logic [13:0] e);
        op(ad, '0, c);
        reg_read(REG_RDATA, v);
        chk("rdata", {18'h0, e}, v);
    endtask : vfy
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    //==========================================================
    // clock, timeout, wire monitor
    initial forever #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    // last data nibble of each verified word carries 00 on top
    always @(posedge clk_in) begin
        pclk <= link.prog_clock_pin;
        if (link.prog_select_pin_n) begin
            nf <= 0;
        end else if (pclk && !link.prog_clock_pin) begin
            nf <= nf + 1;
            if (nf % 4 == 3 && link.dev_nibble_oe) chk("pad", 0, link.nibble_bus[3:2]);
        end
    end
    //==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        reg_read(REG_CTRL, v);
        chk("ctrl", 0, v);
        reg_read(8'h14, v);
        chk("unmapped", 0, v);
        op(10'h154, 14'h1a5e, PG);
        op(10'h155, 14'h2c63, PG);
        op(10'h3ff, 14'h3001, PG);
        vfy(10'h154, VF, 14'h1a5e);
        vfy(10'h155, 6'h03, 14'h2c63);
        vfy(10'h3ff, VF, 14'h3001);
        vfy(10'h000, VF | 6'h04, TW);
        foreach (ow[i]) begin
            op(10'h000, ow[i], PG | 6'h08);
            vfy(10'h000, VF | 6'h08, ow[i]);
            chk("cfg", {ow[i][13:12], ow[i][9:0]}, {dis, src, clr, osc, wk});
        end
        @(posedge clk_in);
        fa <= 10'h155;
        repeat (3) @(posedge clk_in);
        chk("fetch", 14'h2c63, fd);
        op(10'h000, 14'h0001, PG | 6'h04);
        vfy(10'h154, VF, 14'h3fff);
        chk("lock", 1, lck);
        reg_write(REG_CTRL, 32'h20);
        reg_read(REG_STATUS, v);
        chk("close", 0, v[2:0]);
        stop_test();
    end
endmodule : testbench
